// ==== rtl/pss_pkg.sv ====
// Summary of operation
// [RULE1] Phase-out 0: clearing run halts pattern at once
// [RULE2] Phase-out 1: finish current frame, then stop
// [RULE3] Run bit starts or stops pattern generation
// [RULE4] Source select: 0 software bit, 1 pin
// [RULE5] Per-channel two-bit start delay of frames
// [RULE6] Delays latched only at run restart
// [RULE7] Toggle enable toggles pin after frame count
// [RULE8] Toggle count 00..11 means 1..4 frames
// [RULE9] Count ignored while toggle enable clear
// [RULE10] Channel joins pattern only in mode 3
// [RULE11] Per-channel frame mask blanks 0..3 frames
// [RULE12] Host restarts by writing run 0 then 1
// [RULE13] Pin trigger synchronised, level used as run
package pss_pkg;
  localparam logic [7:0] PSS_ADDR_START = 8'h1b;
  localparam logic [7:0] PSS_ADDR_DELAY = 8'h1c;
  localparam logic [7:0] PSS_ADDR_TOGGLE = 8'h1d;
  localparam int PSS_BIT_SRC = 0;
  localparam int PSS_BIT_RUN = 1;
  localparam int PSS_BIT_PHASE = 2;
  localparam int PSS_BIT_TOG_EN = 2;
  localparam logic PSS_SRC_RESET = 1'b1;
  localparam logic [1:0] PSS_MODE_PATTERN = 2'h3;
  localparam int PSS_CHANNELS = 4;
  typedef enum logic [1:0] {PSS_IDLE, PSS_RUN, PSS_PHASE_OUT} pss_state_t;
endpackage

// ==== rtl/pss_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pss_sync
  import pss_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // pss_sync
`default_nettype wire

// ==== rtl/pss_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
module pss_chan
  import pss_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic running,
  input wire logic frame_tick,
  input wire logic [1:0] lag,
  input wire logic [1:0] mode,
  input wire logic [1:0] mask,
  output logic active
);
  logic [1:0] lag_r;
  logic [1:0] wait_r;
  logic [1:0] mask_cnt_r;
  wire in_pattern = (mode == PSS_MODE_PATTERN); // [RULE10]
  wire waiting = (wait_r != 2'h0);
  wire blanked = (mask_cnt_r < mask); // [RULE11]
  always_ff @(posedge clock) begin
    if (reset) begin
      lag_r <= 2'h0;
      wait_r <= 2'h0;
      mask_cnt_r <= 2'h0;
      active <= 1'b0;
    end else begin
      if (start) begin
        lag_r <= lag; // [RULE6]
        wait_r <= lag; // [RULE5]
        mask_cnt_r <= 2'h0;
      end else if (running && frame_tick) begin
        if (waiting) wait_r <= wait_r - 2'h1;
        else if (mask_cnt_r != 2'h3) mask_cnt_r <= mask_cnt_r + 2'h1;
      end
      active <= running && !start && in_pattern && !waiting && !blanked;
    end
  end
endmodule // pss_chan
`default_nettype wire

// ==== rtl/pss_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pss_top
  import pss_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] source_modes,
  input wire logic [7:0] frame_masks,
  input wire logic frame_end,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pattern_run,
  output logic frame_restart,
  output logic [3:0] led_source_active
);
  logic phase_r;
  logic run_bit_r;
  logic src_r;
  logic [7:0] delay_r;
  logic tog_en_r;
  logic [1:0] tog_n_r;
  logic [1:0] tog_cnt_r;
  logic run_req_q;
  logic pin_sync;
  pss_state_t state_r;
  pss_state_t state_nxt;

  wire wr_start = reg_wr && (reg_addr == PSS_ADDR_START);
  wire wr_delay = reg_wr && (reg_addr == PSS_ADDR_DELAY);
  wire wr_tog = reg_wr && (reg_addr == PSS_ADDR_TOGGLE);

  pss_sync u_sync (
    .clock(clock),
    .reset(reset),
    .din(pin_in),
    .dout(pin_sync)
  );

  // Pin is an input while used as trigger; only driven for toggling
  wire run_req = src_r ? pin_sync : run_bit_r; // [RULE4] [RULE13]
  wire run_rise = run_req && !run_req_q; // [RULE12]
  wire running = (state_r != PSS_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSS_IDLE: if (run_rise) state_nxt = PSS_RUN; // [RULE3]
      PSS_RUN: if (!run_req) state_nxt = phase_r ? PSS_PHASE_OUT : PSS_IDLE; // [RULE1] [RULE2]
      PSS_PHASE_OUT: if (frame_end) state_nxt = PSS_IDLE; // [RULE2]
      default: state_nxt = PSS_IDLE;
    endcase
  end

  // Immediate stop in RUN also covers phase_r==0 going straight to IDLE
  wire start_ev = (state_r == PSS_IDLE) && (state_nxt == PSS_RUN);
  wire run_nxt = (state_nxt != PSS_IDLE);

  // Run bit is write-only; it reads back as zero
  always_ff @(posedge clock) begin
    if (reset) begin
      phase_r <= 1'b0;
      run_bit_r <= 1'b0;
      src_r <= PSS_SRC_RESET; // [RULE4]
    end else if (wr_start) begin
      phase_r <= reg_wdata[PSS_BIT_PHASE];
      run_bit_r <= reg_wdata[PSS_BIT_RUN]; // [RULE3]
      src_r <= reg_wdata[PSS_BIT_SRC]; // [RULE4]
    end
  end

  // Delays wait here until the next start copies them into the channels
  always_ff @(posedge clock) begin
    if (reset) begin
      delay_r <= 8'h00;
    end else if (wr_delay) begin
      delay_r <= reg_wdata; // [RULE6]
    end
  end

  // Enable is write-only; only the count reads back
  always_ff @(posedge clock) begin
    if (reset) begin
      tog_en_r <= 1'b0;
      tog_n_r <= 2'h0;
    end else if (wr_tog) begin
      tog_en_r <= reg_wdata[PSS_BIT_TOG_EN]; // [RULE7]
      tog_n_r <= reg_wdata[1:0]; // [RULE8]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= PSS_IDLE;
      run_req_q <= 1'b0;
      pattern_run <= 1'b0;
      frame_restart <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_req_q <= run_req;
      pattern_run <= run_nxt;
      frame_restart <= start_ev;
    end
  end

  // Counter clears whenever toggling cannot happen, so each run starts fresh
  wire tog_hit = (tog_cnt_r == tog_n_r); // [RULE8]
  always_ff @(posedge clock) begin
    if (reset) begin
      tog_cnt_r <= 2'h0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= tog_en_r && !src_r; // [RULE7]
      if (!tog_en_r || !running) begin
        tog_cnt_r <= 2'h0; // [RULE9]
      end else if (frame_end) begin
        if (tog_hit) begin
          tog_cnt_r <= 2'h0;
          pin_out <= !pin_out; // [RULE7]
        end else begin
          tog_cnt_r <= tog_cnt_r + 2'h1;
        end
      end
    end
  end

  wire chan_run = run_nxt && running;
  genvar i;
  generate
    for (i = 0; i < PSS_CHANNELS; i++) begin : g_chan
      pss_chan u_chan (
        .clock(clock),
        .reset(reset),
        .start(start_ev),
        .running(chan_run),
        .frame_tick(frame_end),
        .lag(delay_r[2*i+1:2*i]),
        .mode(source_modes[2*i+1:2*i]),
        .mask(frame_masks[2*i+1:2*i]),
        .active(led_source_active[i])
      );
    end
  endgenerate

  wire [7:0] rd_start = {5'h00, phase_r, 1'b0, src_r};
  wire [7:0] rd_tog = {6'h00, tog_n_r};
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        PSS_ADDR_START: reg_rdata <= rd_start;
        PSS_ADDR_DELAY: reg_rdata <= delay_r;
        PSS_ADDR_TOGGLE: reg_rdata <= rd_tog;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Outputs are registered, so most checks look one edge after the cause
  stop_now_a: assert property (@(posedge clock) disable iff (reset) // [RULE1]
    (state_r == PSS_RUN && !run_req && !phase_r)
    |=> !pattern_run)
    else $error("immediate stop failed");

  phase_enter_a: assert property (@(posedge clock) disable iff (reset) // [RULE2]
    (state_r == PSS_RUN && !run_req && phase_r)
    |=> pattern_run)
    else $error("phase-out stopped at once");

  phase_hold_a: assert property (@(posedge clock) disable iff (reset) // [RULE2]
    (state_r == PSS_PHASE_OUT && !frame_end)
    |=> pattern_run)
    else $error("phase-out ended early");

  phase_end_a: assert property (@(posedge clock) disable iff (reset) // [RULE2]
    (state_r == PSS_PHASE_OUT && frame_end)
    |=> !pattern_run)
    else $error("phase-out did not end");

  start_run_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (state_r == PSS_IDLE && run_rise)
    |=> pattern_run && frame_restart)
    else $error("start missed");

  restart_once_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    frame_restart
    |=> !frame_restart)
    else $error("restart pulse too long");

  no_restart_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (state_r != PSS_IDLE)
    |=> !frame_restart)
    else $error("restart while running");

  idle_quiet_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    !pattern_run
    |-> (led_source_active == 4'h0))
    else $error("channel active while stopped");

  rd_run_wo_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (reg_addr == PSS_ADDR_START)
    |=> !reg_rdata[PSS_BIT_RUN])
    else $error("run bit read back");

  src_sel_a: assert property (@(posedge clock) disable iff (reset) // [RULE4]
    (!src_r && state_r == PSS_IDLE && !run_bit_r)
    |=> !pattern_run)
    else $error("software source ignored");

  pin_start_a: assert property (@(posedge clock) disable iff (reset) // [RULE13]
    (src_r && state_r == PSS_IDLE && !pin_sync)
    |=> !pattern_run)
    else $error("start without pin trigger");

  delay_latch_a: assert property (@(posedge clock) disable iff (reset) // [RULE5] [RULE6]
    start_ev
    |=> g_chan[0].u_chan.lag_r == $past(delay_r[1:0]))
    else $error("delay not latched");

  rd_delay_a: assert property (@(posedge clock) disable iff (reset) // [RULE5]
    (reg_addr == PSS_ADDR_DELAY)
    |=> (reg_rdata == $past(delay_r)))
    else $error("delay register read wrong");

  // Pin toggling
  no_toggle_a: assert property (@(posedge clock) disable iff (reset) // [RULE7] [RULE9]
    !tog_en_r
    |=> $stable(pin_out))
    else $error("pin toggled while disabled");

  toggle_hit_a: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    (tog_en_r && running && frame_end && tog_hit)
    |=> $changed(pin_out))
    else $error("pin did not toggle at count");

  oe_on_a: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    (tog_en_r && !src_r)
    |=> pin_oe)
    else $error("pin not driven while toggling");

  oe_src_a: assert property (@(posedge clock) disable iff (reset) // [RULE13]
    src_r
    |=> !pin_oe)
    else $error("pin driven while used as trigger");

  toggle_cnt_a: assert property (@(posedge clock) disable iff (reset) // [RULE8]
    (tog_en_r && running && frame_end && !tog_hit)
    |=> $stable(pin_out))
    else $error("toggle before count");

  tog_clear_a: assert property (@(posedge clock) disable iff (reset) // [RULE9]
    (!tog_en_r || !running)
    |=> (tog_cnt_r == 2'h0))
    else $error("toggle count kept while idle");

  // Channel gating
  mode_gate_a: assert property (@(posedge clock) disable iff (reset) // [RULE10]
    (source_modes[1:0] != PSS_MODE_PATTERN)
    |=> !led_source_active[0])
    else $error("non-pattern channel active");

  mask_gate_a: assert property (@(posedge clock) disable iff (reset) // [RULE11]
    (g_chan[0].u_chan.blanked)
    |=> !led_source_active[0])
    else $error("masked frame active");

  // Per-channel checks reach into the channel instances
  generate
    for (i = 0; i < PSS_CHANNELS; i++) begin : g_chk
      wait_gate_a: assert property (@(posedge clock) disable iff (reset) // [RULE5]
        g_chan[i].u_chan.waiting
        |=> !led_source_active[i])
        else $error("channel active during start delay");

      wait_step_a: assert property (@(posedge clock) disable iff (reset) // [RULE5]
        (!start_ev && chan_run && frame_end && g_chan[i].u_chan.waiting)
        |=> (g_chan[i].u_chan.wait_r == $past(g_chan[i].u_chan.wait_r) - 2'h1))
        else $error("start delay not counted per frame");

      lag_hold_a: assert property (@(posedge clock) disable iff (reset) // [RULE6]
        !start_ev
        |=> $stable(g_chan[i].u_chan.lag_r))
        else $error("delay changed while running");
    end
  endgenerate

  // Main scenarios: stop, phase-out, toggling, pin start, delayed channel
  run_c: cover property (@(posedge clock) start_ev ##[1:20] !pattern_run);
  phase_c: cover property (@(posedge clock) state_r == PSS_PHASE_OUT ##1 state_r == PSS_IDLE);
  tog_c: cover property (@(posedge clock) pin_oe && $changed(pin_out));
  pin_c: cover property (@(posedge clock) src_r && start_ev);
  lag_c: cover property (@(posedge clock) frame_restart ##[1:40] led_source_active[2]);
endmodule // pss_top
`default_nettype wire

// ==== bench/pss_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pss_host
  import pss_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    // Released data shows no stale value
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    v = reg_rdata;
  endtask
  task automatic restart(input logic [7:0] d);
    wr(PSS_ADDR_START, d & 8'hfd);
    wr(PSS_ADDR_START, d);
  endtask
endmodule // pss_host
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pss_pkg::*;
  logic clock, reset, frame_end, pin_in, last;
  logic [7:0] source_modes, frame_masks, rd;
  wire logic reg_wr, pin_out, pin_oe, pattern_run, frame_restart;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [3:0] act;
  int errors, checks, cycles, t;
  pss_host u_pss_host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  pss_top u_pss_top (.clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .source_modes(source_modes),
    .frame_masks(frame_masks), .frame_end(frame_end), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pattern_run(pattern_run), .frame_restart(frame_restart),
    .led_source_active(act));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clock) frame_end = 1'b1;
      @(negedge clock) frame_end = 1'b0;
    end
    waitn(2);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    frame_end = 1'b0;
    pin_in = 1'b0;
    // Channel four in plain on mode, so it never joins
    source_modes = 8'h7f;
    frame_masks = 8'h00;
    waitn(16);
    reset = 1'b0;
    u_pss_host.rd(PSS_ADDR_START, rd);
    check("start_ctl", rd, 8'h01);
    u_pss_host.rd(8'h20, rd);
    check("unmapped", rd, 8'h00);
    u_pss_host.wr(PSS_ADDR_DELAY, 8'h24);
    u_pss_host.wr(PSS_ADDR_START, 8'h02);
    // Restart pulse stands for one cycle only
    waitn(1);
    check("run", 8'(pattern_run), 8'h01);
    check("restart", 8'(frame_restart), 8'h01);
    waitn(1);
    check("restart_end", 8'(frame_restart), 8'h00);
    u_pss_host.wr(PSS_ADDR_DELAY, 8'h00);
    waitn(2);
    check("active0", 8'(act), 8'h01);
    frames(1);
    check("active1", 8'(act), 8'h03);
    frames(1);
    check("active2", 8'(act), 8'h07);
    u_pss_host.wr(PSS_ADDR_START, 8'h02);
    waitn(2);
    check("no_restart", 8'(frame_restart), 8'h00);
    u_pss_host.wr(PSS_ADDR_START, 8'h00);
    waitn(2);
    check("stop_now", 8'(pattern_run), 8'h00);
    check("stop_act", 8'(act), 8'h00);
    u_pss_host.restart(8'h02);
    waitn(2);
    check("new_delay", 8'(act), 8'h07);
    u_pss_host.wr(PSS_ADDR_START, 8'h06);
    u_pss_host.wr(PSS_ADDR_START, 8'h04);
    waitn(4);
    check("phase_run", 8'(pattern_run), 8'h01);
    u_pss_host.rd(PSS_ADDR_START, rd);
    check("run_wo", rd, 8'h04);
    frames(1);
    check("phase_stop", 8'(pattern_run), 8'h00);
    u_pss_host.wr(PSS_ADDR_START, 8'h00);
    for (int k = 0; k < 4; k++) begin
      u_pss_host.wr(PSS_ADDR_TOGGLE, 8'h04 | 8'(k));
      u_pss_host.restart(8'h02);
      check("oe_on", 8'(pin_oe), 8'h01);
      u_pss_host.rd(PSS_ADDR_TOGGLE, rd);
      check("tog_wo", rd, 8'(k));
      // A multiple of the period gives the same count from any phase
      t = 0;
      last = pin_out;
      repeat (3 * (k + 1)) begin
        frames(1);
        if (pin_out !== last) t++;
        last = pin_out;
      end
      check("toggles", 8'(t), 8'h03);
    end
    u_pss_host.wr(PSS_ADDR_TOGGLE, 8'h03);
    last = pin_out;
    frames(4);
    check("no_toggle", 8'(pin_out), 8'(last));
    check("oe_off", 8'(pin_oe), 8'h00);
    u_pss_host.rd(PSS_ADDR_TOGGLE, rd);
    check("tog_count", rd, 8'h03);
    u_pss_host.wr(PSS_ADDR_START, 8'h01);
    pin_in = 1'b1;
    waitn(5);
    check("pin_start", 8'(pattern_run), 8'h01);
    pin_in = 1'b0;
    waitn(5);
    check("pin_stop", 8'(pattern_run), 8'h00);
    frame_masks = 8'h01;
    u_pss_host.wr(PSS_ADDR_START, 8'h02);
    waitn(2);
    check("masked", 8'(act), 8'h06);
    frames(1);
    check("unmasked", 8'(act), 8'h07);
    // Reset in mid-run stops the pattern and brings the pin trigger back
    reset = 1'b1;
    waitn(2);
    check("rst_run", 8'(pattern_run), 8'h00);
    check("rst_act", 8'(act), 8'h00);
    reset = 1'b0;
    u_pss_host.rd(PSS_ADDR_START, rd);
    check("rst_src", rd, 8'h01);
    waitn(2);
    check("rst_idle", 8'(pattern_run), 8'h00);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
